/* bench/tb.sv */
/*
 * Testbench of the endpoint buffer block: register tests over Avalon-MM
 * and packet traffic through the host model. Assumes nothing else.
 */
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic wreq;
    logic [2:0] ep;
    logic rx_we, rx_done, setup, tx_re, tx_ack;
    logic [7:0] rx_data, tx_data, d, b;
    logic [6:0] tx_len;
    logic [5:0] rx_room, tx_avail, dma_req;
    int err_count = 0;
    int num_checks = 0;

    // Clock
    always #5 clk = ~clk;

    usbeb_top uut (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_usb_ep(ep),
        .i_usb_rx_we(rx_we), .i_usb_rx_data(rx_data), .i_usb_rx_done(rx_done),
        .i_usb_setup(setup), .i_usb_tx_re(tx_re), .i_usb_tx_ack(tx_ack),
        .o_usb_tx_data(tx_data), .o_usb_tx_len(tx_len), .o_usb_rx_room(rx_room),
        .o_usb_tx_avail(tx_avail), .o_dma_req(dma_req));
    usbeb_host_model host (.i_clk(clk), .i_tx_data(tx_data), .o_ep(ep), .o_rx_we(rx_we),
        .o_rx_data(rx_data), .o_rx_done(rx_done), .o_setup(setup), .o_tx_re(tx_re),
        .o_tx_ack(tx_ack));

    // One bus access: hold until waitrequest is sampled low
    task bus_xfer(input logic [7:0] a, input logic w, input logic [7:0] v, output logic [7:0] q);
        adr <= a;
        wdat <= {24'h00_0000, v};
        rd <= ~w;
        wr <= w;
        @(posedge clk);
        while (wreq !== 1'b0) begin
            @(posedge clk);
        end
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task bus_wr(input logic [7:0] a, input logic [7:0] v);
        bus_xfer(a, 1'b1, v, b);
    endtask
    task bus_rd(input logic [7:0] a);
        bus_xfer(a, 1'b0, 8'h00, d);
    endtask

    // Verdict and end of run
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end

    // Test sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus_rd(8'h04); `CHK(d, 8'h00)
        bus_wr(8'h04, 8'hfe); bus_rd(8'h04); `CHK(d, 8'hfe)
        bus_rd(8'he0); `CHK(d, 8'h00)
        bus_wr(8'hc0, 8'h01); host.send_pkt(3'h5, 4, 8'h10, 1'b0);
        bus_rd(8'h00); `CHK(d[5], 1'b0)
        bus_wr(8'h08, 8'h01); bus_wr(8'hc0, 8'h01); host.send_pkt(3'h5, 4, 8'h10, 1'b0);
        bus_rd(8'h00); `CHK(d[5], 1'b1)
        for (int e = 0; e < 6; e++) begin
            bus_wr(8'(32 * e + 40), 8'hff); bus_rd(8'(32 * e + 40));
            `CHK(d, (e == 0) ? 8'hff : (e == 3) ? 8'h3f : 8'h7f)
        end
        bus_wr(8'h40, 8'h01); bus_wr(8'h60, 8'h03);
        bus_wr(8'h80, 8'h11); bus_wr(8'ha0, 8'h13);
        bus_rd(8'h00); `CHK(d[4:1], 4'b1010)
        `CHK({dma_req[4], dma_req[2]}, 2'b11)
        host.send_pkt(3'h1, 70, 8'h20, 1'b0);
        host.send_pkt(3'h1, 3, 8'h80, 1'b0);
        bus_rd(8'h00); `CHK(d[1], 1'b1)
        `CHK(dma_req[1], 1'b1)
        `CHK(rx_room[1], 1'b0)
        bus_rd(8'h4c); `CHK(d, 8'h40)
        for (int k = 0; k < 64; k++) begin
            bus_rd(8'h50); `CHK(d, 8'h20 + 8'(k))
        end
        bus_wr(8'h44, 8'h01); repeat (3) @(posedge clk);
        `CHK(rx_room[1], 1'b1)
        bus_rd(8'h4c); `CHK(d, 8'h03)
        bus_rd(8'h44); `CHK(d[0], 1'b1)
        host.send_pkt(3'h3, 40, 8'h00, 1'b0);
        bus_rd(8'h8c); `CHK(d, 8'h20)
        host.send_pkt(3'h0, 8, 8'h50, 1'b1);
        bus_rd(8'h00); `CHK(d[0], 1'b1)
        `CHK(d[7:6], 2'b11)
        bus_rd(8'h24); `CHK(d[2], 1'b1)
        bus_wr(8'h24, 8'h04); bus_rd(8'h24); `CHK(d[2], 1'b0)
        for (int k = 0; k < 3; k++) bus_wr(8'h70, 8'ha0 + 8'(k));
        bus_wr(8'h64, 8'h02); host.select_ep(3'h2); repeat (4) @(posedge clk);
        `CHK(tx_avail[2], 1'b1)
        `CHK(tx_len, 7'h03)
        for (int k = 0; k < 3; k++) begin
            host.pop_byte(b); `CHK(b, 8'ha0 + 8'(k))
        end
        `CHK(tx_avail[2], 1'b1)
        host.ack_pkt(); repeat (3) @(posedge clk);
        `CHK(tx_avail[2], 1'b0)
        give_verdict();
    end
endmodule

/* bench/usbeb_host_model.sv */
/*
 * Host side model: drives the packet-engine inputs of the block.
 * Assumes its tasks are entered just after a rising clock edge.
 */
module usbeb_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_tx_data,
    output logic [2:0] o_ep,
    output logic o_rx_we,
    output logic [7:0] o_rx_data,
    output logic o_rx_done,
    output logic o_setup,
    output logic o_tx_re,
    output logic o_tx_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle lines at time zero
    initial begin
        o_ep = 3'h0;
        o_rx_we = 1'b0;
        o_rx_data = 8'h00;
        o_rx_done = 1'b0;
        o_setup = 1'b0;
        o_tx_re = 1'b0;
        o_tx_ack = 1'b0;
    end

    // Sends n bytes counting up from b, then marks the packet good
    task send_pkt(input logic [2:0] ep, input int n, input logic [7:0] b, input logic stp);
        o_ep <= ep;
        o_setup <= stp;
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_rx_we <= 1'b1;
            o_rx_data <= b + 8'(k);
        end
        @(posedge i_clk);
        o_rx_we <= 1'b0;
        o_rx_data <= ~o_rx_data; // Released data shows no stale byte
        @(posedge i_clk);
        o_rx_done <= 1'b1;
        @(posedge i_clk);
        o_rx_done <= 1'b0;
        o_setup <= 1'b0;
        @(posedge i_clk);
    endtask

    // Takes the current transmit byte, then pops it
    task pop_byte(output logic [7:0] b);
        @(posedge i_clk);
        @(posedge i_clk);
        b = i_tx_data;
        o_tx_re <= 1'b1;
        @(posedge i_clk);
        o_tx_re <= 1'b0;
    endtask

    // Points the engine at an endpoint
    task select_ep(input logic [2:0] ep);
        o_ep <= ep;
    endtask

    // Acknowledges the IN packet
    task ack_pkt;
        o_tx_ack <= 1'b1;
        @(posedge i_clk);
        o_tx_ack <= 1'b0;
        @(posedge i_clk);
    endtask
endmodule

/* bench/usbeb_top_props.sv */
/*
 * Checker of the endpoint buffer block: bus handshake, DMA capability and
 * packet-engine outputs. Assumes binding to usbeb_top, one clock domain.
 */
module usbeb_top_props (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [2:0] i_usb_ep,
    input wire logic i_usb_rx_we,
    input wire logic [7:0] i_usb_rx_data,
    input wire logic i_usb_rx_done,
    input wire logic i_usb_setup,
    input wire logic i_usb_tx_re,
    input wire logic i_usb_tx_ack,
    input wire logic [7:0] o_usb_tx_data,
    input wire logic [6:0] o_usb_tx_len,
    input wire logic [5:0] o_usb_rx_room,
    input wire logic [5:0] o_usb_tx_avail,
    input wire logic [5:0] o_dma_req
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Bus answers one cycle after an idle request, for one cycle only
    a_answer_next: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus answer late");
    a_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_cause: assert property (!o_avs_waitrequest
        |-> $past(i_avs_read || i_avs_write)) else $error("answer without request");
    a_rd_upper: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == '0)
        else $error("read data upper bits set");
    // Endpoint 3 and endpoint 0 never request DMA
    a_dma_caps: assert property (o_dma_req[0] == 1'b0 && o_dma_req[3] == 1'b0)
        else $error("dma on endpoint without dma");
    // A bulk endpoint never offers both directions at once
    a_one_dir: assert property ((o_usb_rx_room[5:1] & o_usb_tx_avail[5:1]) == 5'h00)
        else $error("endpoint open both ways");
    a_len_bulk: assert property (o_usb_tx_len <= 7'h40)
        else $error("tx length above 64");
    a_len_third: assert property ($past(i_usb_ep) == 3'h3 |-> o_usb_tx_len <= 7'h20)
        else $error("endpoint 3 length above 32");
    a_tx_hold: assert property ($fell(o_usb_tx_avail[2])
        |-> $past(i_usb_tx_ack) || $past(i_usb_tx_ack, 2)) else $error("tx ready lost");
    a_room_ep0: assert property ($fell(i_sys_rst) |-> ##[0:2] o_usb_rx_room[0])
        else $error("ep0 not ready after reset");

    // Main scenarios
    c_read: cover property (!o_avs_waitrequest && i_avs_read);
    c_tx: cover property ($rose(o_usb_tx_avail[2]));
    c_dma: cover property ($rose(o_dma_req[1]));
endmodule

bind usbeb_top usbeb_top_props u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_usb_ep(i_usb_ep), .i_usb_rx_we(i_usb_rx_we), .i_usb_rx_data(i_usb_rx_data),
    .i_usb_rx_done(i_usb_rx_done), .i_usb_setup(i_usb_setup), .i_usb_tx_re(i_usb_tx_re),
    .i_usb_tx_ack(i_usb_tx_ack), .o_usb_tx_data(o_usb_tx_data),
    .o_usb_tx_len(o_usb_tx_len), .o_usb_rx_room(o_usb_rx_room),
    .o_usb_tx_avail(o_usb_tx_avail), .o_dma_req(o_dma_req));

/* design/usbeb_map.svh */
/*
 * Register offsets, bit positions, masks and reset values of the endpoint
 * buffer and status block. Assumes byte addresses on an 8-bit Avalon address.
 */
`ifndef USBEB_MAP_SVH
`define USBEB_MAP_SVH

// Global registers
`define USBEB_IRQ_STATUS_OFS 8'h00
`define USBEB_IRQ_ENABLE_OFS 8'h04
`define USBEB_MODE_OFS 8'h08

// Endpoint block word index (block = endpoint + 1, 32 bytes each)
`define USBEB_EP_CONFIG_IDX 3'h0
`define USBEB_EP_STATUS_IDX 3'h1
`define USBEB_EP_MAXPKT_IDX 3'h2
`define USBEB_EP_RX_COUNT_REG_IDX 3'h3
`define USBEB_EP_FIFO_IDX 3'h4
`define USBEB_EP_LAST_BLK 3'h6

// Bit positions
`define USBEB_IRQ_SETUP_BIT 0
`define USBEB_STAT_RX_BIT 0
`define USBEB_STAT_TX_BIT 1
`define USBEB_STAT_SETUP_BIT 2
`define USBEB_CFG_EN_BIT 0
`define USBEB_CFG_DIR_IN_BIT 1
`define USBEB_MODE_SIX_BIT 0

// Field masks
`define USBEB_CFG_MASK 8'h93
`define USBEB_MAXPKT_EP0_MASK 8'hff
`define USBEB_MAXPKT_EP3_MASK 8'h3f
`define USBEB_MAXPKT_MASK 8'h7f
`define USBEB_CNT_SMALL_MASK 7'h3f
`define USBEB_CNT_MASK 7'h7f

// Reset values
`define USBEB_CFG_RST 8'h00
`define USBEB_MAXPKT_RST 8'h00
`define USBEB_IRQ_EN_RST 8'h00
`define USBEB_MODE_RST 1'b0

`endif

/* design/usbeb_pkg.sv */
/*
 * Types of the endpoint buffer and status block.
 * Assumes nothing of its surroundings.
 */
package usbeb_pkg;
    // Avalon slave handshake state
    typedef enum logic [1:0] {
        USBEB_BUS_IDLE = 2'b01,
        USBEB_BUS_ACK = 2'b10
    } usbeb_bus_e;
endpackage

/* design/usbeb_top.sv */
/*
 * Endpoint buffers and status of a USB device controller: control endpoint 0
 * and bulk/interrupt endpoints 1 to 5, with Avalon-MM register access.
 * Assumes a packet engine on the same clock driving the i_usb_ signals.
 */
// The implementer's own choices: the address map and the Avalon-MM register port.
`include "usbeb_map.svh"

module usbeb_top #(
    parameter int DEPTH_BULK = 64,
    parameter int DEPTH_SMALL = 32
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [2:0] i_usb_ep,
    input wire logic i_usb_rx_we,
    input wire logic [7:0] i_usb_rx_data,
    input wire logic i_usb_rx_done,
    input wire logic i_usb_setup,
    input wire logic i_usb_tx_re,
    input wire logic i_usb_tx_ack,
    output logic [7:0] o_usb_tx_data,
    output logic [6:0] o_usb_tx_len,
    output logic [5:0] o_usb_rx_room,
    output logic [5:0] o_usb_tx_avail,
    output logic [5:0] o_dma_req
);
    usbeb_pkg::usbeb_bus_e bus_reg, bus_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] irq_en_reg, irq_en_next;
    logic six_reg, six_next;
    logic setup_reg, setup_next;
    logic [7:0] txd_reg, txd_next;
    logic [6:0] len_reg, len_next;
    logic [5:0] room_reg, avail_reg, dma_reg;
    logic [7:0] mem [0:767];
    logic [2:0] blk, sel, c_ep;
    logic is_ep, acc_rd, acc_wr, usb_ep_ok, uw_en, cw_en;
    logic [7:0] wd, rd, irq_stat;
    logic [9:0] uw_idx, cw_idx;
    logic [5:0] rx_acc, tx_wr_acc, rx_done_ok, ul_rx_v, ul_tx_v, cl_tx_v;
    logic [5:0] rxrdy_v, txrdy_v, cause, room_v, avail_v, dma_v;
    logic [5:0][6:0] uptr_v, cptr_v, cnt_tx_v;
    logic [5:0][7:0] ep_rd;
    // Address decode and accepted accesses
    assign blk = i_avs_address[7:5];
    assign sel = i_avs_address[4:2];
    assign is_ep = (blk != 3'h0) && (blk <= `USBEB_EP_LAST_BLK);
    assign c_ep = blk - 3'h1;
    assign wd = i_avs_writedata[7:0];
    assign acc_rd = (bus_reg == usbeb_pkg::USBEB_BUS_IDLE) && i_avs_read;
    assign acc_wr = (bus_reg == usbeb_pkg::USBEB_BUS_ACK) && i_avs_write && i_avs_byteenable[0];
    assign usb_ep_ok = i_usb_ep < 3'h6;
    assign irq_stat = {!txrdy_v[0], rxrdy_v[0], cause[5:1], setup_reg};
    for (genvar e = 0; e < 6; e++) begin : g_ep
        localparam bit DBL = (e == 1) || (e == 2) || (e == 4) || (e == 5);
        localparam bit SMALL = (e == 0) || (e == 3);
        localparam logic [6:0] DEPTH = 7'(SMALL ? DEPTH_SMALL : DEPTH_BULK);
        localparam logic [7:0] PMASK = (e == 0) ? `USBEB_MAXPKT_EP0_MASK :
            (e == 3) ? `USBEB_MAXPKT_EP3_MASK : `USBEB_MAXPKT_MASK;
        localparam logic [6:0] CMASK = SMALL ? `USBEB_CNT_SMALL_MASK : `USBEB_CNT_MASK;
        logic [1:0] full_reg, full_next;
        logic lay_reg, lay_next;
        logic [6:0] uptr_reg, uptr_next, cptr_reg, cptr_next;
        logic [1:0][6:0] cnt_reg, cnt_next;
        logic [7:0] cfg_reg, cfg_next, maxp_reg, maxp_next, rd_ep;
        logic en, dir_in, rx_ok, tx_ok, ul_rx, cl_rx, ul_tx, cl_tx, u_sel, c_sel, c_wr;
        assign en = (e == 0) || (cfg_reg[`USBEB_CFG_EN_BIT] && ((e != 5) || six_reg));
        assign dir_in = cfg_reg[`USBEB_CFG_DIR_IN_BIT];
        assign rx_ok = (e == 0) || (en && !dir_in);
        assign tx_ok = (e == 0) || (en && dir_in);
        assign ul_rx = DBL && lay_reg;
        assign cl_rx = DBL && !lay_reg;
        assign ul_tx = DBL ? lay_reg : (e == 0);
        assign cl_tx = DBL ? !lay_reg : (e == 0);
        assign u_sel = usb_ep_ok && (i_usb_ep == 3'(e));
        assign c_sel = is_ep && (c_ep == 3'(e));
        assign c_wr = acc_wr && c_sel;
        // Exported per-endpoint state
        assign rx_acc[e] = rx_ok && !full_reg[ul_rx] && (uptr_reg < DEPTH);
        assign tx_wr_acc[e] = tx_ok && !full_reg[cl_tx] && (cptr_reg < DEPTH);
        assign rx_done_ok[e] = u_sel && i_usb_rx_done && rx_ok && !full_reg[ul_rx];
        assign ul_rx_v[e] = ul_rx;
        assign ul_tx_v[e] = ul_tx;
        assign cl_tx_v[e] = cl_tx;
        assign rxrdy_v[e] = full_reg[cl_rx];
        assign txrdy_v[e] = full_reg[cl_tx];
        assign uptr_v[e] = uptr_reg;
        assign cptr_v[e] = cptr_reg;
        assign cnt_tx_v[e] = cnt_reg[ul_tx];
        assign cause[e] = en && (dir_in ? !full_reg[cl_tx] : full_reg[cl_rx]);
        assign room_v[e] = rx_ok && !full_reg[ul_rx];
        assign avail_v[e] = tx_ok && full_reg[ul_tx];
        // DMA request only on two-layer endpoints
        assign dma_v[e] = DBL && cause[e];
        assign ep_rd[e] = rd_ep;
        // Register read view
        always_comb begin
            case (sel)
                `USBEB_EP_CONFIG_IDX: rd_ep = cfg_reg;
                `USBEB_EP_STATUS_IDX: rd_ep = {5'h00, (e == 0) && setup_reg,
                    full_reg[cl_tx], full_reg[cl_rx]};
                `USBEB_EP_MAXPKT_IDX: rd_ep = maxp_reg;
                `USBEB_EP_RX_COUNT_REG_IDX: rd_ep = {1'b0, cnt_reg[cl_rx] & CMASK};
                `USBEB_EP_FIFO_IDX: rd_ep = mem[{3'(e), cl_rx, cptr_reg[5:0]}];
                default: rd_ep = 8'h00;
            endcase
        end
        // Next buffer state: processor events first, packet-engine events win
        always_comb begin
            full_next = full_reg;
            lay_next = lay_reg;
            uptr_next = uptr_reg;
            cptr_next = cptr_reg;
            cnt_next = cnt_reg;
            cfg_next = cfg_reg;
            maxp_next = maxp_reg;
            if (c_wr && (sel == `USBEB_EP_CONFIG_IDX)) begin
                cfg_next = wd & `USBEB_CFG_MASK;
                full_next = 2'b00;
                lay_next = 1'b0;
                uptr_next = 7'h00;
                cptr_next = 7'h00;
            end
            if (c_wr && (sel == `USBEB_EP_MAXPKT_IDX)) begin
                maxp_next = wd & PMASK;
            end
            if ((acc_rd && c_sel && (sel == `USBEB_EP_FIFO_IDX) && (cptr_reg < cnt_reg[cl_rx]))
                    || (c_wr && (sel == `USBEB_EP_FIFO_IDX) && tx_wr_acc[e])) begin
                cptr_next = cptr_reg + 7'h01;
            end
            if (c_wr && (sel == `USBEB_EP_STATUS_IDX) && wd[`USBEB_STAT_RX_BIT] && rx_ok) begin
                full_next[cl_rx] = 1'b0;
                cptr_next = 7'h00;
            end
            if (c_wr && (sel == `USBEB_EP_STATUS_IDX) && wd[`USBEB_STAT_TX_BIT] && tx_wr_acc[e]
                    ) begin
                full_next[cl_tx] = 1'b1;
                cnt_next[cl_tx] = cptr_reg;
                cptr_next = 7'h00;
            end
            if (u_sel && i_usb_rx_we && rx_acc[e]) begin
                uptr_next = uptr_reg + 7'h01;
            end
            if (rx_done_ok[e]) begin
                full_next[ul_rx] = 1'b1;
                cnt_next[ul_rx] = uptr_reg;
                uptr_next = 7'h00;
            end
            if (u_sel && i_usb_tx_re && tx_ok && (uptr_reg < cnt_reg[ul_tx])) begin
                uptr_next = uptr_reg + 7'h01;
            end
            if (u_sel && i_usb_tx_ack && tx_ok && full_reg[ul_tx]) begin
                full_next[ul_tx] = 1'b0;
                uptr_next = 7'h00;
            end
            // swap layers when both sides allow
            if (DBL && (dir_in ? (full_next[!lay_reg] && !full_next[lay_reg])
                    : (full_next[lay_reg] && !full_next[!lay_reg]))) begin
                lay_next = !lay_reg;
            end
        end
        // Endpoint state registers
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                full_reg <= 2'b00;
                lay_reg <= 1'b0;
                uptr_reg <= 7'h00;
                cptr_reg <= 7'h00;
                cnt_reg <= '0;
                cfg_reg <= `USBEB_CFG_RST;
                maxp_reg <= `USBEB_MAXPKT_RST;
            end else begin
                full_reg <= full_next;
                lay_reg <= lay_next;
                uptr_reg <= uptr_next;
                cptr_reg <= cptr_next;
                cnt_reg <= cnt_next;
                cfg_reg <= cfg_next;
                maxp_reg <= maxp_next;
            end
        end
    end
    // Buffer write ports: packet engine and processor
    assign uw_en = usb_ep_ok && i_usb_rx_we && rx_acc[i_usb_ep];
    assign uw_idx = {i_usb_ep, ul_rx_v[i_usb_ep], uptr_v[i_usb_ep][5:0]};
    assign cw_en = acc_wr && is_ep && (sel == `USBEB_EP_FIFO_IDX) && tx_wr_acc[c_ep];
    assign cw_idx = {c_ep, cl_tx_v[c_ep], cptr_v[c_ep][5:0]};
    // Buffer storage
    always_ff @(posedge i_clk) begin
        if (uw_en) begin
            mem[uw_idx] <= i_usb_rx_data;
        end
        if (cw_en) begin
            mem[cw_idx] <= wd;
        end
    end
    // Register read multiplexer
    always_comb begin
        rd = 8'h00;
        if (is_ep) begin
            rd = ep_rd[c_ep];
        end else begin
            case (i_avs_address)
                `USBEB_IRQ_STATUS_OFS: rd = irq_stat;
                `USBEB_IRQ_ENABLE_OFS: rd = irq_en_reg;
                `USBEB_MODE_OFS: rd = {7'h00, six_reg};
                default: rd = 8'h00;
            endcase
        end
    end
    // Bus handshake, global registers and setup flag
    always_comb begin
        bus_next = bus_reg;
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        irq_en_next = irq_en_reg;
        six_next = six_reg;
        setup_next = setup_reg;
        case (bus_reg)
            usbeb_pkg::USBEB_BUS_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    bus_next = usbeb_pkg::USBEB_BUS_ACK;
                    wait_next = 1'b0;
                end
                if (i_avs_read) begin
                    rdata_next = {24'h00_0000, rd};
                end
            end
            usbeb_pkg::USBEB_BUS_ACK: bus_next = usbeb_pkg::USBEB_BUS_IDLE;
            default: bus_next = usbeb_pkg::USBEB_BUS_IDLE;
        endcase
        if (acc_wr && !is_ep) begin
            case (i_avs_address)
                `USBEB_IRQ_ENABLE_OFS: irq_en_next = wd;
                `USBEB_MODE_OFS: six_next = wd[`USBEB_MODE_SIX_BIT];
                `USBEB_IRQ_STATUS_OFS: begin
                    if (wd[`USBEB_IRQ_SETUP_BIT]) begin
                        setup_next = 1'b0;
                    end
                end
                default: setup_next = setup_next;
            endcase
        end
        if (acc_wr && is_ep && (c_ep == 3'h0) && (sel == `USBEB_EP_STATUS_IDX)
                && wd[`USBEB_STAT_SETUP_BIT]) begin
            setup_next = 1'b0;
        end
        if (rx_done_ok[0] && i_usb_setup) begin
            setup_next = 1'b1;
        end
    end
    // Packet engine side outputs
    always_comb begin
        txd_next = 8'h00;
        len_next = 7'h00;
        if (usb_ep_ok) begin
            txd_next = mem[{i_usb_ep, ul_tx_v[i_usb_ep], uptr_v[i_usb_ep][5:0]}];
            len_next = cnt_tx_v[i_usb_ep];
        end
    end
    // Output and control registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bus_reg <= usbeb_pkg::USBEB_BUS_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            irq_en_reg <= `USBEB_IRQ_EN_RST;
            six_reg <= `USBEB_MODE_RST;
            setup_reg <= 1'b0;
            txd_reg <= 8'h00;
            len_reg <= 7'h00;
            room_reg <= 6'h00;
            avail_reg <= 6'h00;
            dma_reg <= 6'h00;
        end else begin
            bus_reg <= bus_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            irq_en_reg <= irq_en_next;
            six_reg <= six_next;
            setup_reg <= setup_next;
            txd_reg <= txd_next;
            len_reg <= len_next;
            room_reg <= room_v;
            avail_reg <= avail_v;
            dma_reg <= dma_v;
        end
    end
    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_usb_tx_data = txd_reg;
    assign o_usb_tx_len = len_reg;
    assign o_usb_rx_room = room_reg;
    assign o_usb_tx_avail = avail_reg;
    assign o_dma_req = dma_reg;
endmodule
